// ==== rtl/smfc_consts.svh ====
`ifndef SMFC_CONSTS_SVH
`define SMFC_CONSTS_SVH

// Core clock
`define SMFC_CLK_MHZ            250
`define SMFC_CLK_HZ             250000000

// Count pulse train carrier and duty figures
`define SMFC_PWM_CARRIER_HZ     2500
`define SMFC_PWM_PERIOD_CYC     (`SMFC_CLK_HZ / `SMFC_PWM_CARRIER_HZ)
`define SMFC_DUTY_MIN_PCT       10
`define SMFC_DUTY_MAX_PCT       90
`define SMFC_DUTY_FAULT_PCT     98
`define SMFC_DUTY_FAULT_LIM_PCT 95

// Host pin timings, plain defaults in microseconds
`define SMFC_START_US           10
`define SMFC_CLEAR_US           50
`define SMFC_PULSE_MIN_US       20
`define SMFC_PULSE_MAX_US       100
`define SMFC_GAP_US             500
`define SMFC_IDLE_US            1000
`define SMFC_START_CYC          (`SMFC_START_US * `SMFC_CLK_MHZ)
`define SMFC_CLEAR_CYC          (`SMFC_CLEAR_US * `SMFC_CLK_MHZ)
`define SMFC_PULSE_MIN_CYC      (`SMFC_PULSE_MIN_US * `SMFC_CLK_MHZ)
`define SMFC_PULSE_MAX_CYC      (`SMFC_PULSE_MAX_US * `SMFC_CLK_MHZ)
`define SMFC_GAP_CYC            (`SMFC_GAP_US * `SMFC_CLK_MHZ)
`define SMFC_IDLE_CYC           (`SMFC_IDLE_US * `SMFC_CLK_MHZ)

// Rotation tracking: shortest wake interval and the number of doublings
`define SMFC_TRACK_ACT_US       200
`define SMFC_TRACK_LP_US        1600
`define SMFC_TRACK_ACT_CYC      (`SMFC_TRACK_ACT_US * `SMFC_CLK_MHZ)
`define SMFC_TRACK_LP_CYC       (`SMFC_TRACK_LP_US * `SMFC_CLK_MHZ)
`define SMFC_TRACK_ACT_LVLS     3'h3
`define SMFC_TRACK_LP_LVLS      3'h4
`define SMFC_TRACK_QUIET        2'h3

// Counter limits (11-bit two's complement)
`define SMFC_COUNT_MAX          11'h3ff
`define SMFC_COUNT_MIN          11'h400

`endif

// ==== rtl/smfc_mode_ctrl.sv ====
// How it works
// - Any failure enters fault, angle outputs high-Z
// - Normal count duty stays within 10-90 percent
// - Counter failure drives count duty above 95 percent
// - Flag angle, Hall, overflow, regulator, clock, CRC faults
// - Flag supply under/overvoltage and pin open/short
// - Power-up with request high gives active mode
// - Count pin low past start time enables counting
// - First falling edge only after start interval
// - Long low on count pin clears, back active
// - Low-power only with counter on, tracking continues
// - Low-power: no pulse output, count pin ignored
// - Two timed request pulses enter low-power mode
// - Rising request edge leaves low-power mode
// - Wake interval adapts to rotation rate
// - Long low request enters deep idle, high-Z
// - Request high leaves deep idle at once
// - Low-power: angle high-Z, Hall steps still counted
// - Fault: angle high-Z, count pin unused unless the counter failed
// - Carrier 2.5 kHz, count zero gives half duty
// - 11-bit counter, up clockwise, down counter-clockwise
// - Leaving low-power resumes output with saved count
`timescale 1ns/100ps
`include "smfc_consts.svh"

module smfc_mode_ctrl
    import smfc_pkg::*;
#(
    parameter int unsigned START_CYC      = `SMFC_START_CYC,
    parameter int unsigned CLEAR_CYC      = `SMFC_CLEAR_CYC,
    parameter int unsigned PULSE_MIN_CYC  = `SMFC_PULSE_MIN_CYC,
    parameter int unsigned PULSE_MAX_CYC  = `SMFC_PULSE_MAX_CYC,
    parameter int unsigned GAP_CYC        = `SMFC_GAP_CYC,
    parameter int unsigned IDLE_CYC       = `SMFC_IDLE_CYC,
    parameter int unsigned PWM_PERIOD_CYC = `SMFC_PWM_PERIOD_CYC,
    parameter int unsigned TRACK_ACT_CYC  = `SMFC_TRACK_ACT_CYC,
    parameter int unsigned TRACK_LP_CYC   = `SMFC_TRACK_LP_CYC
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           srst,
    // Mode-request pin, low requests idle
    input  wire logic           modeReq,
    // Open-drain count pin
    input  wire logic           countPinIn,
    output logic                countPinOut,
    output logic                countPinOe_n,
    // Hall comparator states
    input  wire logic           hallX,
    input  wire logic           hallY,
    // Diagnostic monitors
    input  wire smfc_fault_type faultIn,
    // Status
    output smfc_mode_type       mode,
    output logic [10:0]         turnCount,
    output logic                angleHiZ,
    output logic                hallEnable,
    output logic                counterFault
);

    localparam logic [23:0] START_LIM  = 24'(START_CYC);
    localparam logic [23:0] CLEAR_LIM  = 24'(CLEAR_CYC);
    localparam logic [23:0] PMIN_LIM   = 24'(PULSE_MIN_CYC);
    localparam logic [23:0] PMAX_LIM   = 24'(PULSE_MAX_CYC);
    localparam logic [23:0] GAP_LIM    = 24'(GAP_CYC);
    localparam logic [23:0] IDLE_LIM   = 24'(IDLE_CYC);
    localparam logic [23:0] TRACK_ACT  = 24'(TRACK_ACT_CYC);
    localparam logic [23:0] TRACK_LP   = 24'(TRACK_LP_CYC);

    smfc_ctrl_state_type s;
    smfc_ctrl_state_type next_s;
    logic                pinDriveLow;
    logic                pwmRun;
    logic                modeRise;
    logic                hostLow;
    logic                tracking;
    logic                wakeTick;
    logic [1:0]          step;
    logic                overflow;
    logic                hallFault;
    logic                anyFault;
    logic                pulseOk;
    logic [1:0]          hallNow;

    // Saturating increment for the duration counters
    function automatic logic [23:0] satInc(input logic [23:0] v);
        return (v == 24'hff_ffff) ? v : v + 24'h00_0001;
    endfunction

    // Position of a Hall state along the clockwise sequence 00,01,11,10
    function automatic logic [1:0] hallPos(input logic [1:0] g);
        return {g[1], g[1] ^ g[0]};
    endfunction

    // Wake interval: shortest interval doubled per level, clamped per mode
    function automatic logic [23:0] wakeInterval(input logic lp, input logic [2:0] lvl);
        logic [2:0] l;
        l = lvl;
        if (lp) begin
            if (l > `SMFC_TRACK_LP_LVLS) l = `SMFC_TRACK_LP_LVLS;
            return TRACK_LP << l;
        end
        if (l > `SMFC_TRACK_ACT_LVLS) l = `SMFC_TRACK_ACT_LVLS;
        return TRACK_ACT << l;
    endfunction

    assign hallNow  = {hallX, hallY};
    assign modeRise = modeReq && !s.modePrev;
    // Our own low phase and its echo are not a host request
    assign hostLow  = !countPinIn && !pinDriveLow && !s.pinDrivePrev;
    assign tracking = s.countEn && (s.mode == SMFC_ARM || s.mode == SMFC_DELAY
                      || s.mode == SMFC_ACTIVE_COUNT || s.mode == SMFC_LOW_POWER);
    assign wakeTick = tracking
                      && s.wakeCnt >= wakeInterval(s.mode == SMFC_LOW_POWER, s.trackLvl)
                         - 24'h00_0001;
    assign step     = hallPos(hallNow) - hallPos(s.hallPrev);
    assign overflow = wakeTick && ((step == 2'h1 && s.turnCount == `SMFC_COUNT_MAX)
                      || (step == 2'h3 && s.turnCount == `SMFC_COUNT_MIN));
    assign hallFault = faultIn.hallBias || faultIn.hallComparator;
    assign anyFault  = (|faultIn) || overflow;
    assign pulseOk   = s.modeLowCnt >= PMIN_LIM && s.modeLowCnt <= PMAX_LIM;

    always_comb begin
        next_s              = s;
        next_s.modePrev     = modeReq;
        next_s.pinDrivePrev = pinDriveLow;
        next_s.modeLowCnt   = modeReq ? 24'h00_0000 : satInc(s.modeLowCnt);
        // While we pull the pin the host level is hidden, so the run is held, not lost
        if (countPinIn || s.mode == SMFC_LOW_POWER) begin
            next_s.pinLowCnt = 24'h00_0000;
        end else if (hostLow) begin
            next_s.pinLowCnt = satInc(s.pinLowCnt);
        end

        // Hall sampling on wake ticks only; a skipped state counts as no step
        if (!tracking) begin
            next_s.wakeCnt  = 24'h00_0000;
            next_s.hallPrev = hallNow;
        end else if (wakeTick) begin
            next_s.wakeCnt  = 24'h00_0000;
            next_s.hallPrev = hallNow;
            if (step == 2'h1 || step == 2'h3) begin
                if (!overflow) begin
                    next_s.turnCount = (step == 2'h1) ? s.turnCount + 11'h001
                                                      : s.turnCount - 11'h001;
                end
                next_s.trackLvl = 3'h0;
                next_s.quietCnt = 2'h0;
            end else if (s.quietCnt == `SMFC_TRACK_QUIET) begin
                next_s.quietCnt = 2'h0;
                if (s.trackLvl < `SMFC_TRACK_LP_LVLS) begin
                    next_s.trackLvl = s.trackLvl + 3'h1;
                end
            end else begin
                next_s.quietCnt = s.quietCnt + 2'h1;
            end
        end else begin
            next_s.wakeCnt = s.wakeCnt + 24'h00_0001;
        end

        case (s.mode)
            SMFC_ACTIVE: begin
                // Arms once per low run, so the tail of a clear pulse cannot re-enable
                if (s.pinLowCnt == START_LIM) begin
                    next_s.mode     = SMFC_ARM;
                    next_s.countEn  = 1'b1;
                    next_s.trackLvl = `SMFC_TRACK_ACT_LVLS;
                    next_s.quietCnt = 2'h0;
                end
            end
            SMFC_ARM: begin
                if (countPinIn) begin
                    next_s.mode     = SMFC_DELAY;
                    next_s.delayCnt = 24'h00_0000;
                end
            end
            SMFC_DELAY: begin
                next_s.delayCnt = s.delayCnt + 24'h00_0001;
                if (s.delayCnt >= START_LIM - 24'h00_0001) begin
                    next_s.mode = SMFC_ACTIVE_COUNT;
                end
            end
            SMFC_ACTIVE_COUNT: begin
                if (s.pinLowCnt >= CLEAR_LIM) begin
                    next_s.mode      = SMFC_ACTIVE;
                    next_s.countEn   = 1'b0;
                    next_s.turnCount = 11'h000;
                    next_s.pulseOne  = 1'b0;
                end else if (modeRise) begin
                    if (pulseOk && s.pulseOne && s.gapCnt <= GAP_LIM) begin
                        next_s.mode     = SMFC_LOW_POWER;
                        next_s.pulseOne = 1'b0;
                    end else begin
                        next_s.pulseOne = pulseOk;
                        next_s.gapCnt   = 24'h00_0000;
                    end
                end else if (s.pulseOne) begin
                    next_s.gapCnt = satInc(s.gapCnt);
                    if (s.gapCnt > GAP_LIM) begin
                        next_s.pulseOne = 1'b0;
                    end
                end
            end
            SMFC_LOW_POWER: begin
                // Count pin is neither watched nor driven here
                if (modeRise) begin
                    next_s.mode = SMFC_ACTIVE_COUNT;
                end
            end
            SMFC_DEEP_IDLE: begin
                if (modeReq) begin
                    next_s.mode = s.countEn ? SMFC_ACTIVE_COUNT : SMFC_ACTIVE;
                end
            end
            SMFC_FAULT: begin
                next_s.mode = SMFC_FAULT;
            end
            default: begin
                next_s.mode = SMFC_FAULT;
            end
        endcase

        if (s.mode != SMFC_FAULT && s.mode != SMFC_DEEP_IDLE && s.modeLowCnt >= IDLE_LIM) begin
            next_s.mode     = SMFC_DEEP_IDLE;
            next_s.pulseOne = 1'b0;
        end

        // Failures outrank every request; only power-up leaves fault
        if (anyFault) begin
            next_s.mode = SMFC_FAULT;
            if (s.countEn && (hallFault || overflow)) begin
                next_s.counterFault = 1'b1;
            end
        end

        next_s.angleHiZ = !(next_s.mode == SMFC_ACTIVE || next_s.mode == SMFC_ARM
                          || next_s.mode == SMFC_DELAY
                          || next_s.mode == SMFC_ACTIVE_COUNT);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s      <= '0;
            s.mode <= SMFC_ACTIVE;
        end else begin
            s <= next_s;
        end
    end

    // Out-of-band duty is the counter's only way to report its own failure
    assign pwmRun = s.mode == SMFC_ACTIVE_COUNT
                    || (s.mode == SMFC_FAULT && s.counterFault);

    smfc_pwm_gen #(
        .PWM_PERIOD_CYC (PWM_PERIOD_CYC)
    ) u_pwm (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .run        (pwmRun),
        .forceFault (s.counterFault),
        .turnCount  (s.turnCount),
        .driveLow   (pinDriveLow)
    );

    assign countPinOut  = s.countEn & ~s.countEn;
    assign countPinOe_n = ~pinDriveLow;
    assign mode         = s.mode;
    assign turnCount    = s.turnCount;
    assign angleHiZ     = s.angleHiZ;
    assign hallEnable   = s.countEn;
    assign counterFault = s.counterFault;

    a_fault_entry: assert property (@(posedge ref_clk) disable iff (srst)
        (|faultIn) |=> s.mode == SMFC_FAULT && s.angleHiZ)
        else $error("failure did not force fault with outputs off");

    a_fault_hold: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_FAULT |=> s.mode == SMFC_FAULT [*4])
        else $error("fault mode was left without power-up");

    a_fault_pin: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_FAULT && !s.counterFault |=> countPinOe_n && s.angleHiZ)
        else $error("count pin used in fault mode");

    a_active_quiet: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_ACTIVE && $past(s.mode) == SMFC_ACTIVE
        |-> countPinOe_n && !s.angleHiZ && !s.countEn)
        else $error("active mode drove count pin or idled outputs");

    a_lp_quiet: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_LOW_POWER |=> countPinOe_n || s.mode != SMFC_LOW_POWER)
        else $error("count pin driven in low-power mode");

    a_clear_zero: assert property (@(posedge ref_clk) disable iff (srst)
        $past(s.mode) == SMFC_ACTIVE_COUNT && s.mode == SMFC_ACTIVE
        |-> s.turnCount == 11'h000 && !s.countEn ##2 countPinOe_n)
        else $error("count clear left counter or output running");

    a_lp_exit: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_LOW_POWER && modeReq && !s.modePrev && !(|faultIn)
        |=> s.mode == SMFC_ACTIVE_COUNT ##2 !countPinOe_n)
        else $error("rising request edge did not resume counting output");

    a_idle_exit: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_DEEP_IDLE && modeReq && !(|faultIn) |=> s.mode != SMFC_DEEP_IDLE)
        else $error("deep idle held with request high");

    a_idle_hiz: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_DEEP_IDLE || s.mode == SMFC_LOW_POWER |-> s.angleHiZ)
        else $error("angle outputs live in idle or low power");

    a_delay_quiet: assert property (@(posedge ref_clk) disable iff (srst)
        s.mode == SMFC_DELAY |=> countPinOe_n)
        else $error("count pin pulled low inside start interval");

endmodule

// ==== rtl/smfc_pkg.sv ====
package smfc_pkg;

    typedef enum logic [2:0] {
        SMFC_ACTIVE       = 3'h0,
        SMFC_ARM          = 3'h1,
        SMFC_DELAY        = 3'h2,
        SMFC_ACTIVE_COUNT = 3'h3,
        SMFC_LOW_POWER    = 3'h4,
        SMFC_DEEP_IDLE    = 3'h5,
        SMFC_FAULT        = 3'h6
    } smfc_mode_type;

    typedef struct packed {
        logic angleBias;
        logic angleCommonMode;
        logic angleGainLoop;
        logic hallBias;
        logic hallComparator;
        logic regulatorUv;
        logic clockBad;
        logic crcBad;
        logic supplyUv;
        logic supplyOv;
        logic pinOpen;
        logic pinShort;
    } smfc_fault_type;

    typedef struct packed {
        smfc_mode_type mode;
        logic [10:0]   turnCount;
        logic          countEn;
        logic          counterFault;
        logic          angleHiZ;
        logic          modePrev;
        logic [23:0]   modeLowCnt;
        logic [23:0]   pinLowCnt;
        logic          pulseOne;
        logic [23:0]   gapCnt;
        logic [23:0]   delayCnt;
        logic [23:0]   wakeCnt;
        logic [2:0]    trackLvl;
        logic [1:0]    quietCnt;
        logic [1:0]    hallPrev;
        logic          pinDrivePrev;
    } smfc_ctrl_state_type;

    typedef struct packed {
        logic [16:0] phaseCnt;
        logic        running;
        logic        driveLow;
    } smfc_pwm_state_type;

endpackage

// ==== rtl/smfc_pwm_gen.sv ====
`timescale 1ns/100ps
`include "smfc_consts.svh"

module smfc_pwm_gen
    import smfc_pkg::*;
#(
    parameter int unsigned PWM_PERIOD_CYC = `SMFC_PWM_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Control
    input  wire logic        run,
    input  wire logic        forceFault,
    input  wire logic [10:0] turnCount,
    // Pin drive, high pulls the open-drain pin low
    output logic             driveLow
);

    smfc_pwm_state_type s;
    smfc_pwm_state_type next_s;
    logic [16:0]        lowLen;

    // Released (high) time of one period for a given count
    function automatic int highCycles(input logic [10:0] cnt, input logic flt);
        int c;
        int p;
        c = int'($signed(cnt));
        p = int'(PWM_PERIOD_CYC);
        if (flt) begin
            return (p * `SMFC_DUTY_FAULT_PCT) / 100;
        end
        return p / 2 + (c * ((p * 2) / 5)) / 1024;
    endfunction

    assign lowLen = 17'(int'(PWM_PERIOD_CYC) - highCycles(turnCount, forceFault));

    always_comb begin
        next_s = s;
        if (!run) begin
            next_s = '0;
        end else begin
            // Each period opens with its falling edge
            if (!s.running || s.phaseCnt == 17'(PWM_PERIOD_CYC - 1)) begin
                next_s.phaseCnt = '0;
            end else begin
                next_s.phaseCnt = s.phaseCnt + 17'h0001;
            end
            next_s.running  = 1'b1;
            next_s.driveLow = next_s.phaseCnt < lowLen;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign driveLow = s.driveLow;

    a_duty_band: assert property (@(posedge ref_clk) disable iff (srst)
        run && !forceFault |-> lowLen * 100 >= 17'(PWM_PERIOD_CYC) * `SMFC_DUTY_MIN_PCT
            && lowLen * 100 <= 17'(PWM_PERIOD_CYC) * `SMFC_DUTY_MAX_PCT)
        else $error("count duty left the valid band");

    a_fault_duty: assert property (@(posedge ref_clk) disable iff (srst)
        run && forceFault |-> lowLen * 100 < 17'(PWM_PERIOD_CYC) * 5)
        else $error("fault duty not above the upper limit");

    a_first_fall: assert property (@(posedge ref_clk) disable iff (srst)
        run && !s.running |=> driveLow ##1 (driveLow || lowLen < 17'h0002))
        else $error("pulse train did not open with a falling edge");

endmodule

// ==== verif/smfc_host_model.sv ====
`timescale 1ns/100ps

module smfc_host_model (
    // Clock
    input  wire logic ref_clk,
    // Device side of the count pin
    input  wire logic countPinOut,
    input  wire logic countPinOe_n,
    // Pins toward the device
    output logic      modeReq,
    output logic      countPinIn
);
    logic hostPull;

    // Pull-up on the open-drain wire, so a released pin reads high
    assign countPinIn = !(hostPull || (!countPinOe_n && !countPinOut));

    initial begin
        modeReq = 1'h1;
        hostPull = 1'h0;
    end

    task automatic set_mode(input logic v);
        @(posedge ref_clk) modeReq <= v;
    endtask

    task automatic set_pull(input logic v);
        @(posedge ref_clk) hostPull <= v;
    endtask

    // Entry and wake pulses share one width
    task automatic mode_low(input int n);
        set_mode(1'h0);
        repeat (n) @(posedge ref_clk);
        modeReq <= 1'h1;
    endtask

    task automatic pull_count(input int n);
        set_pull(1'h1);
        repeat (n) @(posedge ref_clk);
        hostPull <= 1'h0;
    endtask

    // Skips a partial phase, then times one whole low phase of the train
    task automatic low_phase(output int n);
        int t;
        n = 0;
        t = 0;
        while (countPinOe_n === 1'h0 && t < 400) begin
            @(negedge ref_clk);
            t++;
        end
        while (countPinOe_n !== 1'h0 && t < 800) begin
            @(negedge ref_clk);
            t++;
        end
        while (countPinOe_n === 1'h0 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
endmodule

// ==== verif/smfc_mode_ctrl_tb.sv ====
`timescale 1ns/100ps

module smfc_mode_ctrl_tb
    import smfc_pkg::*;
();
    localparam int START = 8;
    localparam int P     = 100;

    logic           ref_clk;
    logic           srst;
    logic           hallX;
    logic           hallY;
    smfc_fault_type faultIn;
    logic           modeReq;
    logic           countPinIn;
    logic           countPinOut;
    logic           countPinOe_n;
    smfc_mode_type  mode;
    logic [10:0]    turnCount;
    logic           angleHiZ;
    logic           hallEnable;
    logic           counterFault;
    int             fails;
    int             cmp_count;
    int             n;

    smfc_mode_ctrl #(
        .START_CYC(START), .CLEAR_CYC(20), .PULSE_MIN_CYC(4), .PULSE_MAX_CYC(10),
        .GAP_CYC(30), .IDLE_CYC(60), .PWM_PERIOD_CYC(P), .TRACK_ACT_CYC(4), .TRACK_LP_CYC(8)
    ) u_dut (
        .ref_clk(ref_clk), .srst(srst), .modeReq(modeReq), .countPinIn(countPinIn),
        .countPinOut(countPinOut), .countPinOe_n(countPinOe_n), .hallX(hallX),
        .hallY(hallY), .faultIn(faultIn), .mode(mode), .turnCount(turnCount),
        .angleHiZ(angleHiZ), .hallEnable(hallEnable), .counterFault(counterFault)
    );

    smfc_host_model u_host (
        .ref_clk(ref_clk), .countPinOut(countPinOut), .countPinOe_n(countPinOe_n),
        .modeReq(modeReq), .countPinIn(countPinIn)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val(32'(got), 32'(exp));
    endtask

    task automatic chk_mode(input smfc_mode_type got, input smfc_mode_type exp);
        chk_val(32'(got), 32'(exp));
    endtask

    task automatic wait_mode(input smfc_mode_type m, input int lim);
        int t;
        t = 0;
        while (mode !== m && t < lim) begin
            @(negedge ref_clk);
            t++;
        end
        chk_mode(mode, m);
        if (mode !== m) begin
            results();
        end
    endtask

    task automatic hall(input logic [1:0] s, input int hold);
        @(posedge ref_clk) {hallX, hallY} <= s;
        repeat (hold) @(posedge ref_clk);
    endtask

    task automatic t_idle();
        chk_mode(mode, SMFC_ACTIVE);
        chk_bit(hallEnable, 1'h0);
        u_host.set_mode(1'h0);
        repeat (50) @(negedge ref_clk);
        chk_bit(angleHiZ, 1'h0);
        wait_mode(SMFC_DEEP_IDLE, 30);
        chk_bit(angleHiZ, 1'h1);
        u_host.set_mode(1'h1);
        wait_mode(SMFC_ACTIVE, 3);
    endtask

    task automatic t_enable();
        u_host.pull_count(START + 4);
        @(negedge ref_clk);
        chk_bit(hallEnable, 1'h1);
        n = 0;
        while (countPinOe_n !== 1'h0 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk_val(32'(n >= START && n < 200), 1);
        chk_bit(countPinOut, 1'h0);
        chk_mode(mode, SMFC_ACTIVE_COUNT);
        u_host.low_phase(n);
        chk_val(n, P / 2);
    endtask

    task automatic t_hall();
        hall(2'h1, 40);
        hall(2'h3, 40);
        hall(2'h2, 40);
        chk_val(32'(turnCount), 3);
        hall(2'h3, 40);
        chk_val(32'(turnCount), 2);
        hall(2'h2, 40);
        // Widths below and above the allowed band must not pair
        for (int w = 2; w < 20; w += 13) begin
            u_host.mode_low(w);
            repeat (4) @(posedge ref_clk);
            u_host.mode_low(w);
            repeat (40) @(negedge ref_clk);
            chk_mode(mode, SMFC_ACTIVE_COUNT);
        end
    endtask

    task automatic t_lowpower();
        u_host.mode_low(6);
        repeat (5) @(posedge ref_clk);
        u_host.mode_low(6);
        wait_mode(SMFC_LOW_POWER, 4);
        chk_bit(angleHiZ, 1'h1);
        chk_bit(hallEnable, 1'h1);
        u_host.pull_count(30);
        n = 0;
        repeat (200) begin
            @(negedge ref_clk);
            n += int'(countPinOe_n === 1'h0);
        end
        chk_val(n, 0);
        chk_mode(mode, SMFC_LOW_POWER);
        hall(2'h0, 140);
        chk_val(32'(turnCount), 4);
        u_host.mode_low(6);
        wait_mode(SMFC_ACTIVE_COUNT, 4);
        u_host.low_phase(n);
        chk_val(n, P / 2);
    endtask

    task automatic t_clear();
        u_host.set_pull(1'h1);
        wait_mode(SMFC_ACTIVE, 150);
        u_host.set_pull(1'h0);
        repeat (3) @(negedge ref_clk);
        chk_val(32'(turnCount), 0);
        chk_bit(countPinOe_n, 1'h1);
        chk_mode(mode, SMFC_ACTIVE);
    endtask

    task automatic t_counter_fault();
        t_enable();
        @(posedge ref_clk) faultIn.hallBias <= 1'h1;
        wait_mode(SMFC_FAULT, 4);
        chk_bit(counterFault, 1'h1);
        u_host.low_phase(n);
        chk_val(32'(n > 0 && n < 5), 1);
        @(posedge ref_clk) faultIn <= '0;
        repeat (50) @(negedge ref_clk);
        chk_mode(mode, SMFC_FAULT);
    endtask

    // Every monitor bit alone must trip the fault state, which then ignores the request pin
    task automatic t_faults();
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk) srst <= 1'h1;
            repeat (12) @(posedge ref_clk);
            srst <= 1'h0;
            @(posedge ref_clk) faultIn <= smfc_fault_type'(12'h001 << i);
            wait_mode(SMFC_FAULT, 4);
            chk_bit(angleHiZ, 1'h1);
            chk_bit(countPinOe_n, 1'h1);
            u_host.set_mode(1'h0);
            faultIn <= '0;
            repeat (70) @(negedge ref_clk);
            chk_mode(mode, SMFC_FAULT);
            u_host.set_mode(1'h1);
        end
    endtask

    initial begin
        ref_clk = 1'h0;
        srst = 1'h1;
        hallX = 1'h0;
        hallY = 1'h0;
        faultIn = '0;
        fails = 0;
        cmp_count = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'h0;
        @(negedge ref_clk);
        t_idle();
        t_enable();
        t_hall();
        t_lowpower();
        t_clear();
        t_counter_fault();
        t_faults();
        results();
    end
endmodule
